// ==== core/scu_pkg.sv ====
/*
 * Package for the alignment and commit register block: register addresses,
 * system control bit positions, reset values and the descriptor reset image.
 * Assumes a serial port front end that presents decoded byte accesses.
 */
package scu_pkg;
	localparam logic [11:0] ADDR_SYSTEM_CONTROL = 12'h230;
	localparam logic [11:0] ADDR_COMMIT = 12'h232;
	localparam logic [11:0] ADDR_DESC_FIRST = 12'hA00;
	localparam logic [11:0] ADDR_DESC_LAST = 12'hA16;
	localparam int DESC_COUNT = 23;
	localparam int DESC_IDX_W = 5;

	localparam int BIT_DIS_POWERON_ALIGN = 3;
	localparam int BIT_PD_ALIGN = 2;
	localparam int BIT_PD_DIST_REF = 1;
	localparam int BIT_SOFT_ALIGN = 0;
	localparam int BIT_COMMIT = 0;
	localparam logic [7:0] SYSCTL_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;

	// Descriptor opcodes: bit 7 set marks an opcode byte, otherwise an entry header.
	localparam logic [7:0] OP_COMMIT_UPDATE = 8'hA0;
	localparam logic [7:0] OP_TERMINATOR = 8'hFF;
	localparam logic OP_FLAG = 1'b1;

	// Reset image: byte count minus one, address high, address low, per range.
	localparam logic [7:0] DESC_RESET [DESC_COUNT] = '{
		8'h07, 8'h00, 8'h00,
		8'h0F, 8'h00, 8'h10,
		8'h3F, 8'h00, 8'hF0,
		8'h3F, 8'h01, 8'h90,
		8'h02, 8'h02, 8'h30,
		OP_COMMIT_UPDATE, OP_TERMINATOR,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
	};

	typedef struct packed {
		logic disPowerOnAlign;
		logic pdAlign;
		logic pdDistRef;
		logic softAlign;
	} scu_sysctl_t;

	typedef struct packed {
		logic wrEn;
		logic rdEn;
		logic [11:0] addr;
		logic [7:0] wdata;
	} scu_req_t;
endpackage

// ==== core/scu_regs.sv ====
/*
 * System control, commit strobe and descriptor registers of the alignment block.
 * Assumes the serial port decoder hands over byte accesses in the core_clk domain,
 * and that the nonvolatile controller walks the descriptors through its own read port.
 */
`timescale 1ns/10ps
module scu_regs
	import scu_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Register access from the serial port
	input wire scu_req_t req,
	output logic [7:0] rdata,
	output logic rvalid,
	// Alignment pin, active low
	input wire logic alignPin_n,
	// Controls to the distribution section
	output scu_sysctl_t sysctl,
	output logic alignHold,
	output logic alignEvent,
	output logic commitPulse,
	// Descriptor read port for the nonvolatile controller
	input wire logic [DESC_IDX_W-1:0] descIdx,
	output logic [7:0] descData,
	output logic descIsOpcode,
	output logic descIsTerminator
);
	logic [7:0] sysctlReg_ff;
	logic commitPend_ff;
	logic [7:0] desc_ff [DESC_COUNT];
	logic [7:0] nxt_rdata;
	logic alignLow;
	logic alignLowPrev_ff;
	logic descHit;
	logic [DESC_IDX_W-1:0] wrIdx;

	assign descHit = (req.addr >= ADDR_DESC_FIRST) && (req.addr <= ADDR_DESC_LAST);
	assign wrIdx = DESC_IDX_W'(req.addr - ADDR_DESC_FIRST);
	// Soft bit 1 acts as pin low; either source asserts alignment.
	assign alignLow = sysctlReg_ff[BIT_SOFT_ALIGN] | ~alignPin_n;

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysctlReg_ff <= SYSCTL_RESET;
		end else if (req.wrEn && req.addr == ADDR_SYSTEM_CONTROL) begin
			sysctlReg_ff <= req.wdata;
		end
	end

	// Drive the control outputs from flops.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sysctl <= '0;
		end else begin
			sysctl.disPowerOnAlign <= sysctlReg_ff[BIT_DIS_POWERON_ALIGN];
			sysctl.pdAlign <= sysctlReg_ff[BIT_PD_ALIGN];
			sysctl.pdDistRef <= sysctlReg_ff[BIT_PD_DIST_REF];
			sysctl.softAlign <= sysctlReg_ff[BIT_SOFT_ALIGN];
		end
	end

	// Hold outputs static while asserted, pulse on release, unless powered down.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			alignLowPrev_ff <= 1'b0;
			alignHold <= 1'b0;
			alignEvent <= 1'b0;
		end else begin
			alignLowPrev_ff <= alignLow;
			alignHold <= alignLow & ~sysctlReg_ff[BIT_PD_ALIGN];
			alignEvent <= alignLowPrev_ff & ~alignLow & ~sysctlReg_ff[BIT_PD_ALIGN];
		end
	end

	// Commit request is taken on one edge and executed on the next, then clears.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			commitPend_ff <= 1'b0;
			commitPulse <= 1'b0;
		end else begin
			commitPend_ff <= req.wrEn && req.addr == ADDR_COMMIT && req.wdata[BIT_COMMIT];
			commitPulse <= commitPend_ff;
		end
	end

	// Descriptor storage with its covering reset image.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < DESC_COUNT; i++) begin
				desc_ff[i] <= DESC_RESET[i];
			end
		end else if (req.wrEn && descHit) begin
			desc_ff[wrIdx] <= req.wdata;
		end
	end

	// Controller reads entries by ascending index and stops on the terminator.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			descData <= BYTE_ZERO;
			descIsOpcode <= 1'b0;
			descIsTerminator <= 1'b0;
		end else if (descIdx < DESC_IDX_W'(DESC_COUNT)) begin
			descData <= desc_ff[descIdx];
			descIsOpcode <= desc_ff[descIdx][7] == OP_FLAG;
			descIsTerminator <= desc_ff[descIdx] == OP_TERMINATOR;
		end else begin
			descData <= OP_TERMINATOR;
			descIsOpcode <= 1'b1;
			descIsTerminator <= 1'b1;
		end
	end

	always_comb begin
		nxt_rdata = BYTE_ZERO;
		if (req.addr == ADDR_SYSTEM_CONTROL) begin
			nxt_rdata = sysctlReg_ff;
		end else if (req.addr == ADDR_COMMIT) begin
			nxt_rdata = {7'h00, commitPend_ff};
		end else if (descHit) begin
			nxt_rdata = desc_ff[wrIdx];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata <= BYTE_ZERO;
			rvalid <= 1'b0;
		end else begin
			rdata <= req.rdEn ? nxt_rdata : BYTE_ZERO;
			rvalid <= req.rdEn;
		end
	end
endmodule // scu_regs

// ==== sim/scu_regs_props.sv ====
/* Checker for scu_regs. Bound to every scu_regs instance by the bind below. */
`timescale 1ns/10ps
module scu_regs_props
	import scu_pkg::*;
(
	// Watched ports
	input wire logic core_clk,
	input wire logic rst_n,
	input wire scu_req_t req,
	input wire logic alignPin_n,
	input wire scu_sysctl_t sysctl,
	input wire logic alignHold,
	input wire logic alignEvent,
	input wire logic commitPulse,
	input wire logic [7:0] descData,
	input wire logic descIsTerminator
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_commit_copy: assert property (req.wrEn && req.addr == ADDR_COMMIT && req.wdata[0] |-> ##2 commitPulse)
		else $error("no commit");
	a_commit_clears: assert property (commitPulse |=> !commitPulse) else $error("commit stuck");
	a_soft_hold: assert property (sysctl.softAlign && !sysctl.pdAlign |-> alignHold) else $error("no hold");
	a_pin_hold: assert property ($past(!alignPin_n) && !sysctl.pdAlign |-> alignHold) else $error("pin lost");
	a_release_event: assert property ($fell(alignHold) && !sysctl.pdAlign |-> alignEvent) else $error("no event");
	a_pd_hold: assert property (alignHold |-> !sysctl.pdAlign) else $error("hold while off");
	a_desc_end: assert property (descIsTerminator |-> descData == OP_TERMINATOR) else $error("bad end");
	a_reset_ctl: assert property ($rose(rst_n) |-> sysctl == '0) else $error("bad reset");
	cover property (commitPulse);
	cover property (alignEvent);
	cover property (descIsTerminator);
endmodule // scu_regs_props
bind scu_regs scu_regs_props i_props (.core_clk, .rst_n, .req, .alignPin_n, .sysctl, .alignHold, .alignEvent,
	.commitPulse, .descData, .descIsTerminator);

// ==== sim/scu_host.sv ====
/* Host model on the register port. Assumes the bench supplies core_clk. */
`timescale 1ns/10ps
module scu_host
	import scu_pkg::*;
(
	// Bus
	input wire logic core_clk,
	output scu_req_t req,
	input wire logic [7:0] rdata
);
	initial req = '0;
	task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
		@(negedge core_clk);
		req = '{w, !w, a, d};
		@(negedge core_clk);
		q = rdata;
		req = '0;
	endtask
endmodule // scu_host

// ==== sim/tb.sv ====
/* Top testbench. Expects scu_host as the host on the register port. */
`timescale 1ns/10ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin errCount++; $display("unexpected %s %h %h", n, e, g); end end
module tb;
	import scu_pkg::*;
	logic core_clk = 0, rst_n = 0, alignPin_n = 1;
	logic [4:0] descIdx = 0;
	logic [7:0] rdata, q, descData;
	logic rvalid, alignHold, alignEvent, commitPulse, descIsOpcode, descIsTerminator;
	scu_req_t req;
	scu_sysctl_t sysctl;
	int errCount = 0, testsRun = 0, cyc = 0;
	always #5 core_clk = ~core_clk;
	scu_host i_host (.core_clk, .req, .rdata);
	scu_regs i_dut (.core_clk, .rst_n, .req, .rdata, .rvalid, .alignPin_n, .sysctl, .alignHold, .alignEvent,
		.commitPulse, .descIdx, .descData, .descIsOpcode, .descIsTerminator);
	task automatic completeRun;
		$display("errors %0d checks %0d", errCount, testsRun);
		if (errCount == 0 && testsRun > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge core_clk) if (++cyc == 1000) begin
		errCount++;
		completeRun;
	end
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		i_host.acc(0, a, 8'h00, q);
		`CHK("rd", e, q)
		`CHK("rvalid", 1'b1, rvalid)
	endtask
	task automatic wr2(input logic [11:0] a, input logic [7:0] d);
		i_host.acc(1, a, d, q);
		@(posedge core_clk);
		#1;
	endtask
	task automatic tCtl;
		rd(ADDR_SYSTEM_CONTROL, SYSCTL_RESET);
		wr2(ADDR_SYSTEM_CONTROL, 8'h0E);
		`CHK("sysctl", 4'hE, sysctl)
		rd(ADDR_SYSTEM_CONTROL, 8'h0E);
		wr2(ADDR_SYSTEM_CONTROL, 8'h00);
	endtask
	task automatic tSoft;
		wr2(ADDR_SYSTEM_CONTROL, 8'h01);
		`CHK("hold", 1'b1, alignHold)
		wr2(ADDR_SYSTEM_CONTROL, 8'h00);
		`CHK("event", 1'b1, alignEvent)
		wr2(ADDR_SYSTEM_CONTROL, 8'h05);
		`CHK("pdhold", 1'b0, alignHold)
		wr2(ADDR_SYSTEM_CONTROL, 8'h04);
		`CHK("pdevent", 1'b0, alignEvent)
		wr2(ADDR_SYSTEM_CONTROL, 8'h00);
		@(negedge core_clk) alignPin_n = 0;
		repeat (3) @(posedge core_clk);
		#1 `CHK("pin", 1'b1, alignHold)
		@(negedge core_clk) alignPin_n = 1;
	endtask
	task automatic tCommit;
		wr2(ADDR_COMMIT, 8'h01);
		`CHK("commit", 1'b1, commitPulse)
		@(posedge core_clk) #1 `CHK("commit", 1'b0, commitPulse)
		rd(ADDR_COMMIT, BYTE_ZERO);
		rd(12'h231, BYTE_ZERO);
	endtask
	task automatic tDesc;
		for (int i = 0; i <= DESC_COUNT; i++) begin
			@(negedge core_clk) descIdx = 5'(i);
			@(posedge core_clk) #1 `CHK("desc", (i < DESC_COUNT) ? DESC_RESET[i] : OP_TERMINATOR, descData)
			`CHK("end", 1'(i == 16 || i == DESC_COUNT), descIsTerminator)
			`CHK("opcode", (i < DESC_COUNT) ? DESC_RESET[i][7] : 1'b1, descIsOpcode)
		end
	endtask
	initial begin
		repeat (5) @(negedge core_clk);
		rst_n = 1;
		tCtl;
		tSoft;
		tCommit;
		tDesc;
		completeRun;
	end
endmodule // tb
